// [core/sfsr_top.sv]
// Two-byte status register of a serial flash and its status read command.
// Storage runs on clk; the serial pins run on spi_sck while spi_cs_n is low.
// The command decoder and program/erase engine sit outside and use clk.
//
// Summary of operation
// - Status read accepted at any time, even busy
// - After opcode 05h, status bit every clock
// - After byte two, restart with byte one
// - Each repetition current; busy resampled per byte
// - Select high ends read, output released
// - Lock set blocks sector protect commands
// - Lock clears at power-up, not reset command
// - Pin asserted: lock may only go 0 to 1
// - Byte-one write alters only bit 7
// - Byte one bit 5 is error flag
// - Byte one bit 4 shows protect pin
// - Byte one bits 3:2 soft protection state
// - Byte one bit 1 is write-enable latch
// - Bit 0 of both bytes is busy
// - Byte two bit 4 reset command enable
// - Byte two bit 3 lockdown enable
// - Byte two bits 2,1 suspend flags
// - Byte-two write alters only bits 4,3
// - Latch clears at reset and op end
`timescale 1ns/1ps
`default_nettype none

module sfsr_top (
  // System clock and power-up reset
  input wire logic clk,
  input wire logic reset_n,
  // Serial pins
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  // Write-protect pin, active low
  input wire logic wp_n,
  // Surrounding flash logic
  input wire sfsr_pkg::sfsr_dev_status_t dev_status,
  input wire sfsr_pkg::sfsr_wr_req_t wr_req,
  input wire sfsr_pkg::sfsr_wel_evt_t wel_evt,
  // Control outputs to the command decoder
  output logic write_enabled,
  output logic protection_lock_flag,
  output logic protect_cmds_allowed,
  output logic lockdown_cmds_allowed,
  output logic reset_cmds_allowed
);

  // Builds the two status bytes, byte one in the upper half
  function automatic logic [15:0] status_word(
    input logic lock,
    input logic wpn,
    input logic write_enable_latch,
    input logic reset_cmd_enable,
    input logic lockdown_enable,
    input sfsr_pkg::sfsr_dev_status_t st
  );
    logic [7:0] b1;
    logic [7:0] b2;
    b1 = 8'h00;
    b2 = 8'h00;
    b1[sfsr_pkg::B1_LOCK] = lock;
    b1[sfsr_pkg::B1_UNUSED] = 1'b0;
    b1[sfsr_pkg::B1_ERR] = st.prog_err;
    b1[sfsr_pkg::B1_WPP] = wpn;
    b1[sfsr_pkg::B1_SWP_HI:sfsr_pkg::B1_SWP_LO] = st.soft_prot;
    b1[sfsr_pkg::B1_WEL] = write_enable_latch;
    b1[sfsr_pkg::BX_BUSY] = st.busy;
    b2[sfsr_pkg::BX_BUSY] = st.busy;
    b2[sfsr_pkg::B2_RESET_CMD_ENABLE] = reset_cmd_enable;
    b2[sfsr_pkg::B2_SLE] = lockdown_enable;
    b2[sfsr_pkg::B2_PS] = st.prog_susp;
    b2[sfsr_pkg::B2_ES] = st.erase_susp;
    return {b1, b2};
  endfunction : status_word

  // Storage domain state
  logic lock_r, lock_nxt;
  logic wel_r, wel_nxt;
  logic reset_cmd_enable_r, reset_cmd_enable_nxt;
  logic sle_r, sle_nxt;
  logic [2:0] wp_q_r, wp_q_nxt;
  logic wp_n_r, wp_n_nxt;
  logic [2:0] ack_q_r, ack_q_nxt;
  logic ack_seen_r, ack_seen_nxt;
  logic req_r, req_nxt;
  logic [15:0] hold_r, hold_nxt;
  logic prot_ok_r, prot_ok_nxt;

  // Serial capture side, rising edge
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic [6:0] shin_r, shin_nxt;
  logic opc_seen_r, opc_seen_nxt;
  logic rd_active_r, rd_active_nxt;
  logic [2:0] req_q_r, req_q_nxt;
  logic ack_r, ack_nxt;
  logic [15:0] link_r, link_nxt;

  // Serial output side, falling edge
  logic [3:0] out_cnt_r, out_cnt_nxt;
  logic [7:0] osh_r, osh_nxt;
  logic so_r, so_nxt;
  logic so_oe_r, so_oe_nxt;

  always_comb begin
    lock_nxt = lock_r;
    wel_nxt = wel_r;
    reset_cmd_enable_nxt = reset_cmd_enable_r;
    sle_nxt = sle_r;
    wp_q_nxt = {wp_q_r[1:0], wp_n};
    wp_n_nxt = wp_n_r;
    ack_q_nxt = {ack_q_r[1:0], ack_r};
    ack_seen_nxt = ack_seen_r;
    req_nxt = req_r;
    hold_nxt = hold_r;
    // A pin change counts once the last two stages agree
    if (wp_q_r[1] == wp_q_r[2]) begin
      wp_n_nxt = wp_q_r[2];
    end
    if (ack_q_r[1] == ack_q_r[2]) begin
      ack_seen_nxt = ack_q_r[2];
    end
    if (wr_req.wr_one && wel_r) begin
      if (wp_n_r || !lock_r || wr_req.data[sfsr_pkg::B1_LOCK]) begin
        lock_nxt = wr_req.data[sfsr_pkg::B1_LOCK];
      end
    end
    // Byte-two write, bits 4 and 3
    if (wr_req.wr_two && wel_r) begin
      reset_cmd_enable_nxt = wr_req.data[sfsr_pkg::B2_RESET_CMD_ENABLE];
      sle_nxt = wr_req.data[sfsr_pkg::B2_SLE];
    end
    // Latch clears when a write ends
    if (wr_req.wr_one || wr_req.wr_two || wel_evt.op_done ||
        wel_evt.wel_clear || (wel_evt.reset_cmd && reset_cmd_enable_r)) begin
      wel_nxt = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (wel_evt.wel_set) begin
      wel_nxt = 1'b1;
    end
    // Fresh snapshot once the last one was taken
    if (ack_seen_r == req_r) begin
      hold_nxt = status_word(lock_r, wp_n_r, wel_r, reset_cmd_enable_r, sle_r,
                             dev_status);
      req_nxt = ~req_r;
    end
    prot_ok_nxt = ~lock_nxt;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lock_r <= sfsr_pkg::LOCK_RST;
      wel_r <= sfsr_pkg::WEL_RST;
      reset_cmd_enable_r <= sfsr_pkg::RESET_CMD_ENABLE_RST;
      sle_r <= sfsr_pkg::SLE_RST;
      wp_q_r <= {3{sfsr_pkg::WP_N_RST}};
      wp_n_r <= sfsr_pkg::WP_N_RST;
      ack_q_r <= 3'h0;
      ack_seen_r <= 1'b0;
      req_r <= 1'b0;
      hold_r <= sfsr_pkg::HOLD_RST;
      prot_ok_r <= ~sfsr_pkg::LOCK_RST;
    end else begin
      lock_r <= lock_nxt;
      wel_r <= wel_nxt;
      reset_cmd_enable_r <= reset_cmd_enable_nxt;
      sle_r <= sle_nxt;
      wp_q_r <= wp_q_nxt;
      wp_n_r <= wp_n_nxt;
      ack_q_r <= ack_q_nxt;
      ack_seen_r <= ack_seen_nxt;
      req_r <= req_nxt;
      hold_r <= hold_nxt;
      prot_ok_r <= prot_ok_nxt;
    end
  end

  assign write_enabled = wel_r;
  assign protection_lock_flag = lock_r;
  assign protect_cmds_allowed = prot_ok_r;
  assign lockdown_cmds_allowed = sle_r;
  assign reset_cmds_allowed = reset_cmd_enable_r;

  // Opcode capture; hold_r is stable while req and ack differ
  always_comb begin
    bit_cnt_nxt = bit_cnt_r;
    shin_nxt = shin_r;
    opc_seen_nxt = opc_seen_r;
    rd_active_nxt = rd_active_r;
    req_q_nxt = {req_q_r[1:0], req_r};
    ack_nxt = ack_r;
    link_nxt = link_r;
    if (!opc_seen_r) begin
      shin_nxt = {shin_r[5:0], spi_si};
      bit_cnt_nxt = bit_cnt_r + 3'h1;
      if (bit_cnt_r == sfsr_pkg::LAST_BIT) begin
        opc_seen_nxt = 1'b1;
        // No busy check on the read
        rd_active_nxt = ({shin_r, spi_si} == sfsr_pkg::OPC_READ_STATUS);
      end
    end
    if ((req_q_r[1] == req_q_r[2]) && (req_q_r[2] != ack_r)) begin
      link_nxt = hold_r;
      ack_nxt = req_q_r[2];
    end
  end

  // Select high clears the frame; no serial edge comes outside a frame
  always_ff @(posedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      bit_cnt_r <= sfsr_pkg::FIRST_BIT;
      shin_r <= 7'h00;
      opc_seen_r <= 1'b0;
      rd_active_r <= 1'b0;
      req_q_r <= 3'h0;
      ack_r <= 1'b0;
      link_r <= sfsr_pkg::HOLD_RST;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      shin_r <= shin_nxt;
      opc_seen_r <= opc_seen_nxt;
      rd_active_r <= rd_active_nxt;
      req_q_r <= req_q_nxt;
      ack_r <= ack_nxt;
      link_r <= link_nxt;
    end
  end

  // Output shifter, falling edge
  always_comb begin
    out_cnt_nxt = out_cnt_r;
    osh_nxt = osh_r;
    so_nxt = so_r;
    so_oe_nxt = so_oe_r;
    if (rd_active_r) begin
      so_oe_nxt = 1'b1;
      out_cnt_nxt = out_cnt_r + 4'h1;
      if (out_cnt_r[2:0] == sfsr_pkg::FIRST_BIT) begin
        osh_nxt = out_cnt_r[3] ? link_r[7:0] : link_r[15:8];
        so_nxt = osh_nxt[7];
        osh_nxt = {osh_nxt[6:0], 1'b0};
      end else begin
        so_nxt = osh_r[7];
        osh_nxt = {osh_r[6:0], 1'b0};
      end
    end
  end

  // Select high releases output at once
  always_ff @(negedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      out_cnt_r <= 4'h0;
      osh_r <= 8'h00;
      so_r <= 1'b0;
      so_oe_r <= 1'b0;
    end else begin
      out_cnt_r <= out_cnt_nxt;
      osh_r <= osh_nxt;
      so_r <= so_nxt;
      so_oe_r <= so_oe_nxt;
    end
  end

  assign spi_so = so_r;
  assign spi_so_oe = so_oe_r;

endmodule : sfsr_top
`default_nettype wire

// [core/sfsr_pkg.sv]
// Shared constants and carrier types for the status register block.
// Assumes a single clk domain for storage and a serial clock domain at the pins.
package sfsr_pkg;

  // Status read opcode
  localparam logic [7:0] OPC_READ_STATUS = 8'h05;

  // Byte one field positions
  localparam int B1_LOCK = 7;
  localparam int B1_UNUSED = 6;
  localparam int B1_ERR = 5;
  localparam int B1_WPP = 4;
  localparam int B1_SWP_HI = 3;
  localparam int B1_SWP_LO = 2;
  localparam int B1_WEL = 1;
  localparam int BX_BUSY = 0;

  // Byte two field positions
  localparam int B2_RESET_CMD_ENABLE = 4;
  localparam int B2_SLE = 3;
  localparam int B2_PS = 2;
  localparam int B2_ES = 1;

  // Values after power-up reset
  localparam logic LOCK_RST = 1'b0;
  localparam logic WEL_RST = 1'b0;
  localparam logic RESET_CMD_ENABLE_RST = 1'b0;
  localparam logic SLE_RST = 1'b0;
  localparam logic WP_N_RST = 1'b1;
  localparam logic [15:0] HOLD_RST = 16'h0000;

  // Bit counter limits of the serial side
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT = 3'h0;

  // Live state of the surrounding flash logic, same clock as clk
  typedef struct packed {
    logic busy;
    logic prog_err;
    logic [1:0] soft_prot;
    logic prog_susp;
    logic erase_susp;
  } sfsr_dev_status_t;

  // Decoded status write commands, one-cycle pulses with their data byte
  typedef struct packed {
    logic wr_one;
    logic wr_two;
    logic [7:0] data;
  } sfsr_wr_req_t;

  // Write-enable latch events, one-cycle pulses
  typedef struct packed {
    logic wel_set;
    logic wel_clear;
    logic op_done;
    logic reset_cmd;
  } sfsr_wel_evt_t;

endpackage : sfsr_pkg

// [dv/sfsr_top_monitor.sv]
// Port checker for the status register block.
// Bound to sfsr_top; clk domain only, serial pins seen as levels.
`timescale 1ns/1ps
`default_nettype none
module sfsr_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Pins
  input wire logic spi_cs_n,
  input wire logic spi_so_oe,
  input wire logic wp_n,
  // Flash side
  input wire sfsr_pkg::sfsr_wr_req_t wr_req,
  input wire sfsr_pkg::sfsr_wel_evt_t wel_evt,
  // Controls
  input wire logic write_enabled,
  input wire logic protection_lock_flag,
  input wire logic protect_cmds_allowed,
  input wire logic lockdown_cmds_allowed,
  input wire logic reset_cmds_allowed
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic we1;
  logic we2;
  assign we1 = write_enabled && wr_req.wr_one;
  assign we2 = write_enabled && wr_req.wr_two;
  property p_wel_wr;
    (wr_req.wr_one || wr_req.wr_two) && !wel_evt.wel_set |=> !write_enabled;
  endproperty
  a_wel_wr: assert property (p_wel_wr) else $error("latch kept");
  property p_lock_set; we1 && wr_req.data[7] |=> protection_lock_flag;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock");
  property p_lock_wp; !wp_n [*5] |=> !$fell(protection_lock_flag);
  endproperty
  a_lock_wp: assert property (p_lock_wp) else $error("lock fell");
  property p_lock_hold; !we1 |=> $stable(protection_lock_flag); endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock moved");
  property p_b2_wr;
    we2 |=> reset_cmds_allowed == $past(wr_req.data[4]) &&
      lockdown_cmds_allowed == $past(wr_req.data[3]);
  endproperty
  a_b2_wr: assert property (p_b2_wr) else $error("byte two");
  property p_b2_hold;
    !we2 |=> $stable(reset_cmds_allowed) && $stable(lockdown_cmds_allowed);
  endproperty
  a_b2_hold: assert property (p_b2_hold) else $error("b2 moved");
  property p_prot; protect_cmds_allowed != protection_lock_flag; endproperty
  a_prot: assert property (p_prot) else $error("protect gate");
  property p_set; wel_evt.wel_set |=> write_enabled; endproperty
  a_set: assert property (p_set) else $error("latch not set");
  property p_cs; spi_cs_n |-> !spi_so_oe; endproperty
  a_cs: assert property (p_cs) else $error("so driven");
  c_lock: cover property (we1 && wr_req.data[7]);
  c_read: cover property ($rose(spi_so_oe));
  c_rcmd: cover property (wel_evt.reset_cmd && reset_cmds_allowed);
endmodule : sfsr_monitor
bind sfsr_top sfsr_monitor sfsr_monitor_i (.clk(clk), .reset_n(reset_n),
  .spi_cs_n(spi_cs_n), .spi_so_oe(spi_so_oe), .wp_n(wp_n),
  .wr_req(wr_req), .wel_evt(wel_evt), .write_enabled(write_enabled),
  .protection_lock_flag(protection_lock_flag),
  .protect_cmds_allowed(protect_cmds_allowed),
  .lockdown_cmds_allowed(lockdown_cmds_allowed),
  .reset_cmds_allowed(reset_cmds_allowed));
`default_nettype wire

// [dv/sfsr_host.sv]
// Serial host model issuing mode 0 frames, 125 ns serial clock.
// Clock idles low outside frames; SI toggles after the opcode.
`timescale 1ns/1ps
`default_nettype none
module sfsr_host (
  // Pins
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe,
  // Captured bytes
  output logic [7:0] rx,
  output logic stb,
  output logic seen
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    rx = 8'h00;
    stb = 1'b0;
    seen = 1'b0;
  end
  task automatic frame(input logic [7:0] op, input int nb);
    logic [7:0] b;
    b = 8'h00;
    seen = 1'b0;
    #37 cs_n = 1'b0;
    for (int i = 0; i < 8 + nb; i++) begin
      si = (i < 8) ? op[7 - i] : ~si;
      #62.5 sck = 1'b1;
      seen = seen | so_oe;
      // Undriven SO captured as unknown
      b = {b[6:0], so_oe ? so : 1'bx};
      if (i > 7 && i % 8 == 7 && op == 8'h05) begin
        rx = b;
        stb = ~stb;
      end
      #62.5 sck = 1'b0;
    end
    #40 cs_n = 1'b1;
  endtask : frame
endmodule : sfsr_host
`default_nettype wire

// [dv/sfsr_top_tb.sv]
// Self-checking bench for the status register block.
// Host model reads status; flash side driven on clk.
`timescale 1ns/1ps
`default_nettype none
module sfsr_top_tb;
  logic clk, reset_n, wp_n, sck, cs_n, si, so, so_oe, h_stb, h_seen, w;
  logic lk, we, rs, sl, we_o, lk_o, pa_o, la_o, ra_o;
  logic [7:0] h_rx, b1, b2;
  logic [5:0] s;
  sfsr_pkg::sfsr_dev_status_t ds;
  sfsr_pkg::sfsr_wr_req_t wr;
  sfsr_pkg::sfsr_wel_evt_t ev;
  logic [7:0] q[$];
  int mismatches, total_checks;
  sfsr_top sfsr_top_i (.clk(clk), .reset_n(reset_n), .spi_sck(sck),
    .spi_cs_n(cs_n), .spi_si(si), .spi_so(so), .spi_so_oe(so_oe),
    .wp_n(wp_n), .dev_status(ds), .wr_req(wr), .wel_evt(ev),
    .write_enabled(we_o), .protection_lock_flag(lk_o),
    .protect_cmds_allowed(pa_o), .lockdown_cmds_allowed(la_o),
    .reset_cmds_allowed(ra_o));
  sfsr_host sfsr_host_i (.sck(sck), .cs_n(cs_n), .si(si), .so(so),
    .so_oe(so_oe), .rx(h_rx), .stb(h_stb), .seen(h_seen));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  task automatic put(input logic [9:0] r, input logic [3:0] e);
    @(posedge clk);
    wr <= r;
    ev <= e;
    @(posedge clk);
    wr <= 10'h000;
    ev <= 4'h0;
  endtask : put
  task automatic trial(input int t);
    logic [7:0] d;
    logic [1:0] k;
    int e;
    d = 8'($urandom);
    k = 2'($urandom);
    s = 6'($urandom);
    w = 1'($urandom);
    e = $urandom_range(1, 3);
    @(posedge clk);
    wp_n <= w;
    ds <= s;
    repeat (6) @(posedge clk);
    if (k[1]) put(10'h000, 4'h8);
    we = k[1];
    put({k[0], ~k[0], d}, 4'h0);
    // Writes with the latch low are dropped
    if (we && k[0] && !(lk && !w)) lk = d[7];
    if (we && !k[0]) begin
      rs = d[4];
      sl = d[3];
    end
    put(10'h000, 4'h8);
    put(10'h000, 4'h8 >> e);
    we = (e == 3) && !rs;
    #1;
    chk({3'h0, we_o, lk_o, pa_o, la_o, ra_o},
      {3'h0, we, lk, !lk, sl, rs});
    b1 = {lk, 1'b0, s[4], w, s[3:2], we, s[5]};
    b2 = {3'h0, rs, sl, s[1], s[0], s[5]};
    repeat (2) begin
      q.push_back(b1);
      q.push_back(b2);
    end
    sfsr_host_i.frame(8'h05, 32);
    #1;
    chk({7'h0, so_oe}, 8'h00);
    $display("test %0d done", t);
  endtask : trial
  always @(h_stb) begin
    if (q.size() != 0) begin
      chk(h_rx, q.pop_front());
    end
  end
  initial begin
    #2000000;
    mismatches++;
    end_sim();
  end
  initial begin
    reset_n = 1'b0;
    wp_n = 1'b1;
    ds = 6'h00;
    wr = 10'h000;
    ev = 4'h0;
    mismatches = 0;
    total_checks = 0;
    {lk, we, rs, sl} = 4'h0;
    void'($urandom(32'h70981612));
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    chk({3'h0, we_o, lk_o, pa_o, la_o, ra_o}, 8'h04);
    for (int t = 0; t < 10; t++) trial(t);
    q.push_back(b1);
    sfsr_host_i.frame(8'h05, 13);
    #1;
    chk({7'h0, so_oe}, 8'h00);
    sfsr_host_i.frame(8'h9f, 16);
    chk({7'h0, h_seen}, 8'h00);
    chk(8'(q.size()), 8'h00);
    $display("test abort done");
    end_sim();
  end
endmodule : sfsr_top_tb
`default_nettype wire
